// ---- include/mrls_pkg.sv ----
/*
  Constants and types shared by the module end and the host end of the
  reset, boot-mode and indicator link.
  Assumes a single 100 MHz clock, sys_clk, in both ends.
*/
`default_nettype none
package mrls_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_HOLD_MS = 50;
  localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned BLANK_NS = 50_000_000;
  localparam int unsigned BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COUNT_W = 32;
  localparam logic [1:0] LED_SPEED = 2'h0;
  localparam logic [1:0] LED_ACT = 2'h1;
  localparam logic [1:0] LED_GREEN = 2'h2;
  localparam logic [1:0] LED_RED = 2'h3;

  typedef enum logic [1:0] {
    MRLS_BOOT = 2'b00,
    MRLS_APP = 2'b01,
    MRLS_UPGRADE = 2'b10,
    MRLS_PROGRAM = 2'b11
  } mrls_mode_t;

  typedef enum logic [1:0] {
    MRLS_H_HOLD = 2'b00,
    MRLS_H_WAIT = 2'b01,
    MRLS_H_RUN = 2'b10
  } mrls_host_t;
endpackage
`default_nettype wire

// ---- include/mrls_if.sv ----
/*
  Interface joining the module end and the host end.
  Assumes both ends share sys_clk; all lines are plain one-way levels.
*/
`default_nettype none
interface mrls_if;
  logic moduleReset;
  logic bootModeSelectIn;
  logic [3:0] indicatorLines;
  modport device (input moduleReset, input bootModeSelectIn, output indicatorLines);
  modport host (output moduleReset, output bootModeSelectIn, input indicatorLines);
endinterface
`default_nettype wire

// ---- core/mrls_blank_stretch.sv ----
/*
  Stretches a one-cycle receive pulse into a visible blank of the
  activity light. Assumes sys_clk and a synchronous active-high reset.
*/
`default_nettype none
module mrls_blank_stretch
  import mrls_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic trigger,
  output logic blank
);
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (trigger) begin
      next_count = COUNT_W'(BLANK_CYCLES);
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign blank = (count != '0);
endmodule
`default_nettype wire

// ---- core/mrls_device.sv ----
/*
  Module end: reset input, boot-mode strap and the four indicator lines.
  Assumes link status, receive pulse and firmware light patterns come
  from the network and firmware logic on sys_clk.
*/
`default_nettype none
module mrls_device
  import mrls_pkg::*;
(
  input wire logic sys_clk,
  mrls_if.device link,
  input wire logic linkUp,
  input wire logic linkIs100,
  input wire logic packetReceived,
  input wire logic firmwareGreen,
  input wire logic firmwareRed,
  input wire logic upgradeDone,
  output logic inReset,
  output logic [1:0] opMode,
  output logic programRequest,
  output logic linkSpeedIndicator,
  output logic linkActivityIndicator,
  output logic firmwareStatusGreen,
  output logic firmwareStatusRed
);
  logic modeMeta, modeSync, sampled, blank;
  logic next_sampled, next_programRequest;
  mrls_mode_t mode, next_mode;
  logic [3:0] leds, next_leds;

  // Reset is the module's own pin, active high
  wire logic rst = link.moduleReset;

  mrls_blank_stretch mrls_blank_stretch_i (
    .sys_clk(sys_clk),
    .reset(rst),
    .trigger(packetReceived),
    .blank(blank)
  );

  always_comb begin
    next_mode = mode;
    next_sampled = sampled;
    next_programRequest = 1'b0;
    // Strap read while sampled is clear; later, a low strap in APP moves to PROGRAM
    if (!sampled) begin
      next_sampled = 1'b1;
      next_mode = modeSync ? MRLS_APP : MRLS_UPGRADE;
    end else begin
      case (mode)
        MRLS_APP: begin
          if (!modeSync) begin
            next_mode = MRLS_PROGRAM;
            next_programRequest = 1'b1;
          end
        end
        MRLS_UPGRADE, MRLS_PROGRAM: begin
          if (upgradeDone) begin
            next_mode = MRLS_BOOT;
            next_sampled = 1'b0;
          end
        end
        MRLS_BOOT: next_mode = MRLS_BOOT;
        default: next_mode = MRLS_BOOT;
      endcase
    end
    next_leds[LED_SPEED] = linkUp & linkIs100;
    next_leds[LED_ACT] = linkUp & ~blank;
    next_leds[LED_GREEN] = firmwareGreen;
    next_leds[LED_RED] = firmwareRed;
  end

  always_ff @(posedge sys_clk) begin
    modeMeta <= link.bootModeSelectIn;
    modeSync <= modeMeta;
    if (rst) begin
      mode <= MRLS_BOOT;
      sampled <= 1'b0;
      programRequest <= 1'b0;
      leds <= 4'h0;
      inReset <= 1'b1;
    end else begin
      mode <= next_mode;
      sampled <= next_sampled;
      programRequest <= next_programRequest;
      leds <= next_leds;
      inReset <= 1'b0;
    end
  end

  // Onboard lights and external lines come from the same flops
  assign link.indicatorLines = leds;
  assign linkSpeedIndicator = leds[LED_SPEED];
  assign linkActivityIndicator = leds[LED_ACT];
  assign firmwareStatusGreen = leds[LED_GREEN];
  assign firmwareStatusRed = leds[LED_RED];
  assign opMode = mode;
endmodule
`default_nettype wire

// ---- core/mrls_host.sv ----
/*
  Host end: drives the module reset and mode lines and watches the
  indicator lines. Assumes supplyGood comes from a brownout monitor.
*/
`default_nettype none
module mrls_host
  import mrls_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  mrls_if.host link,
  input wire logic supplyGood,
  input wire logic resetRequest,
  input wire logic wantRunMode,
  output logic moduleRunning,
  output logic [3:0] indicatorSeen
);
  mrls_host_t state, next_state;
  logic [COUNT_W-1:0] count, next_count;
  logic rstOut, next_rstOut, mdOut, next_mdOut;

  always_comb begin
    next_state = state;
    next_count = count;
    next_rstOut = rstOut;
    next_mdOut = wantRunMode;
    case (state)
      MRLS_H_HOLD: begin
        next_rstOut = 1'b1;
        next_count = '0;
        if (supplyGood && !resetRequest) begin
          next_state = MRLS_H_WAIT;
        end
      end
      MRLS_H_WAIT: begin
        next_rstOut = 1'b1;
        if (!supplyGood || resetRequest) begin
          next_state = MRLS_H_HOLD;
        end else if (count >= COUNT_W'(HOLD_CYCLES - 1)) begin
          next_state = MRLS_H_RUN;
          next_rstOut = 1'b0;
        end else begin
          next_count = count + 1'b1;
        end
      end
      MRLS_H_RUN: begin
        next_rstOut = 1'b0;
        if (!supplyGood || resetRequest) begin
          next_state = MRLS_H_HOLD;
          next_rstOut = 1'b1;
        end
      end
      default: next_state = MRLS_H_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= MRLS_H_HOLD;
      count <= '0;
      rstOut <= 1'b1;
      mdOut <= 1'b1;
      moduleRunning <= 1'b0;
      indicatorSeen <= 4'h0;
    end else begin
      state <= next_state;
      count <= next_count;
      rstOut <= next_rstOut;
      mdOut <= next_mdOut;
      moduleRunning <= (next_state == MRLS_H_RUN);
      indicatorSeen <= link.indicatorLines;
    end
  end

  assign link.moduleReset = rstOut;
  assign link.bootModeSelectIn = mdOut;
endmodule
`default_nettype wire

// ---- sim/mrls_link_props.sv ----
/* Checker on the host-to-module link.
   Assumes one sys_clk, host reset synchronous active high, hold of 20. */
`default_nettype none
module mrls_link_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic moduleReset,
  input wire logic bootModeSelectIn,
  input wire logic [3:0] indicatorLines
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  host_reset_lines_a: assert property ($fell(reset) |-> moduleReset && bootModeSelectIn)
    else $error("lines not parked after host reset");
  leds_dark_reset_a: assert property (moduleReset |=> indicatorLines == 4'h0)
    else $error("indicator lit while module in reset");
  reset_hold_len_a: assert property ($fell(moduleReset) |-> $past(moduleReset, 20))
    else $error("module reset released too early");
  reset_hold_rise_a: assert property ($rose(moduleReset) |-> moduleReset [*8])
    else $error("module reset pulse too short");
  dark_at_release_a: assert property ($fell(moduleReset) |-> indicatorLines == 4'h0)
    else $error("indicator lit at reset release");
  release_stays_low_a: assert property ($fell(moduleReset) |=> !moduleReset)
    else $error("module reset bounced after release");
endmodule
`default_nettype wire

// ---- sim/test_module_reset_mode_and_led_status.sv ----
/* Bench joining host and module ends by the link interface.
   Assumes host hold shortened to 20; the blank is too long to wait out. */
`default_nettype none
module test_module_reset_mode_and_led_status
  import mrls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
  logic sys_clk = 0, reset = 1, supplyGood = 0, resetRequest = 0, wantRunMode = 1;
  logic linkUp = 0, linkIs100 = 0, packetReceived = 0, fwGreen = 0, fwRed = 0;
  logic upgradeDone = 0, inReset, programRequest, moduleRunning, spd, act, grn, red;
  logic [1:0] opMode;
  logic [3:0] indicatorSeen;
  int mismatches = 0, compares = 0;
  mrls_if link();
  mrls_device mrls_device_i (.sys_clk(sys_clk), .link(link), .linkUp(linkUp),
    .linkIs100(linkIs100), .packetReceived(packetReceived), .firmwareGreen(fwGreen),
    .firmwareRed(fwRed), .upgradeDone(upgradeDone), .inReset(inReset), .opMode(opMode),
    .programRequest(programRequest), .linkSpeedIndicator(spd),
    .linkActivityIndicator(act), .firmwareStatusGreen(grn), .firmwareStatusRed(red));
  mrls_host #(.HOLD_CYCLES(20)) mrls_host_i (.sys_clk(sys_clk), .reset(reset), .link(link),
    .supplyGood(supplyGood), .resetRequest(resetRequest), .wantRunMode(wantRunMode),
    .moduleRunning(moduleRunning), .indicatorSeen(indicatorSeen));
  mrls_link_props mrls_link_props_i (.sys_clk(sys_clk), .reset(reset),
    .moduleReset(link.moduleReset), .bootModeSelectIn(link.bootModeSelectIn),
    .indicatorLines(link.indicatorLines));
  initial forever #5 sys_clk = ~sys_clk;
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Host walks reset, then the strap decides the mode
  task t_boot(input logic run);
    int i;
    @(posedge sys_clk);
    wantRunMode <= run;
    linkUp <= 1;
    resetRequest <= 1;
    cyc(3);
    resetRequest <= 0;
    @(negedge sys_clk);
    `CHK(link.moduleReset, 1'b1)
    `CHK(link.indicatorLines, 4'h0)
    `CHK(inReset, 1'b1)
    for (i = 0; i < 100 && moduleRunning !== 1'b1; i++) @(negedge sys_clk);
    if (i == 100) begin
      mismatches++;
      print_verdict;
    end
    cyc(4);
    @(negedge sys_clk);
    `CHK(opMode, run ? MRLS_APP : MRLS_UPGRADE)
    `CHK(inReset, 1'b0)
    $display("boot test done");
  endtask
  task t_prog;
    int i;
    @(posedge sys_clk);
    wantRunMode <= 0;
    for (i = 0; i < 10 && programRequest !== 1'b1; i++) @(negedge sys_clk);
    `CHK(i < 10, 1'b1)
    @(negedge sys_clk);
    `CHK(opMode, MRLS_PROGRAM)
    `CHK(programRequest, 1'b0)
    @(posedge sys_clk);
    upgradeDone <= 1;
    @(posedge sys_clk);
    upgradeDone <= 0;
    cyc(3);
    @(negedge sys_clk);
    `CHK(opMode, MRLS_UPGRADE)
    $display("program test done");
  endtask
  // Every combination of linkUp, linkIs100, fwGreen and fwRed for the four lights, with no receive pulse
  task t_leds;
    logic [3:0] pat;
    for (int k = 0; k < 16; k++) begin
      @(posedge sys_clk);
      {fwRed, fwGreen, linkIs100, linkUp} <= 4'(k);
      cyc(3);
      @(negedge sys_clk);
      pat = {k[3], k[2], k[0], k[1] & k[0]};
      `CHK(link.indicatorLines, pat)
      `CHK({red, grn, act, spd}, pat)
      `CHK(indicatorSeen, pat)
    end
    $display("light test done");
  endtask
  // Blank lasts far longer than this run can watch
  task t_blank;
    @(posedge sys_clk);
    packetReceived <= 1;
    @(posedge sys_clk);
    packetReceived <= 0;
    cyc(2);
    @(negedge sys_clk);
    `CHK(act, 1'b0)
    cyc(500);
    @(negedge sys_clk);
    `CHK(act, 1'b0)
    $display("blank test done");
  endtask
  initial begin
    cyc(8);
    reset <= 0;
    supplyGood <= 1;
    t_boot(1'b0);
    t_boot(1'b1);
    t_prog;
    t_leds;
    t_blank;
    print_verdict;
  end
endmodule
`default_nettype wire
